// *** core/tsg_pkg.sv ***
// Operation
// RULE1: Gate check one passes only when current privilege <= gate descriptor privilege.
// RULE2: Gate check two passes only when requested privilege <= gate descriptor privilege.
// RULE3: Through a task gate the target descriptor privilege is never read or compared.
// RULE4: Any failing gate check denies entry; both must pass.
// RULE5: In long mode any task-gate transfer raises a protection fault.
// RULE6: Far jump leaves nested flag and link field unchanged in both tasks.
// RULE7: Call, interrupts, exceptions set new nested flag and link old selector.
// RULE8: Interrupt return switches only with nested flag set, target from link field.
// RULE9: Interrupt-return switch clears the outgoing task's nested flag.
// RULE10: Busy indicator is bit 9 of the descriptor word at byte +4.
// RULE11: Far jump clears outgoing busy and sets incoming busy.
// RULE12: Far jump to an already busy task raises a protection fault.
// RULE13: Call-type switches set incoming busy; outgoing busy stays set.
// RULE14: Call-type switch to an already busy task raises a protection fault.
// RULE15: Interrupt return clears outgoing busy; incoming busy untouched.
// RULE16: Failed privilege check abandons the switch unmodified and faults.
// RULE17: Interrupt and exception switches through a gate skip the gate privilege check.
package tsg_pkg;

    localparam logic [2:0] TSG_BUSY_BIT = 3'h1;
    localparam logic [2:0] TSG_DESC_HI_BYTE = 3'h4;
    localparam logic [3:0] TSG_BUSY_POS = 4'h9;
    localparam logic [1:0] TSG_PL_RESET = 2'h0;

    localparam logic [11:0] TSG_ADDR_CTRL = 12'h000;
    localparam logic [11:0] TSG_ADDR_STATE = 12'h004;
    localparam logic [11:0] TSG_ADDR_RESULT = 12'h008;
    localparam logic [11:0] TSG_ADDR_IRQ_STAT = 12'h00C;
    localparam logic [11:0] TSG_ADDR_IRQ_EN = 12'h010;
    localparam logic [11:0] TSG_ADDR_IRQ_CLR = 12'h014;
    localparam logic [11:0] TSG_ADDR_CMD = 12'h018;

    localparam int TSG_IRQ_DONE = 0;
    localparam int TSG_IRQ_FAULT = 1;
    localparam int TSG_IRQ_NOSW = 2;

    typedef enum logic [2:0]
    {
        TSG_OP_JUMP,
        TSG_OP_CALL,
        TSG_OP_SWINT,
        TSG_OP_HWINT,
        TSG_OP_EXCEPT,
        TSG_OP_INTERRUPT_RETURN_OP
    } tsg_op_t;

    typedef enum logic [1:0]
    {
        TSG_RES_NONE,
        TSG_RES_SWITCHED,
        TSG_RES_FAULT,
        TSG_RES_NOSWITCH
    } tsg_res_t;

    // Switch request as written by software
    typedef struct packed
    {
        tsg_op_t op;
        logic via_gate;
        logic [1:0] gate_dpl;
        logic [1:0] requested_privilege_level;
        logic [1:0] tss_dpl;
        logic target_busy;
        logic [15:0] target_sel;
    } tsg_req_t;

    // Bookkeeping effects of one switch
    typedef struct packed
    {
        logic old_nt_clr;
        logic new_nt_set;
        logic new_link_wr;
        logic old_busy_clr;
        logic new_busy_set;
        logic [15:0] link_sel;
        logic [15:0] new_sel;
    } tsg_eff_t;

endpackage : tsg_pkg

// *** core/tsg_ctl.sv ***
`timescale 1ns/1ps
module tsg_ctl
    import tsg_pkg::*;
(
    input wire logic pclk, // 40 MHz clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    output logic irq // Level interrupt
);

    logic wr_en;
    logic rd_en;
    tsg_req_t req_q;
    logic long_mode_q;
    logic [1:0] cpl_q;
    logic nt_q;
    logic [15:0] cur_sel_q;
    logic [15:0] link_q;
    tsg_res_t res_q;
    tsg_eff_t eff_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_en_q;
    logic go;
    logic addr_ok;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign addr_ok = paddr == TSG_ADDR_CTRL || paddr == TSG_ADDR_STATE
        || paddr == TSG_ADDR_RESULT || paddr == TSG_ADDR_IRQ_STAT
        || paddr == TSG_ADDR_IRQ_EN || paddr == TSG_ADDR_IRQ_CLR
        || paddr == TSG_ADDR_CMD;
    assign pslverr = psel && penable && !addr_ok;
    assign go = wr_en && paddr == TSG_ADDR_CMD && pwdata[0];

    // Decision logic
    logic is_gate_op;
    logic is_nest_op;
    logic gate_chk1;
    logic gate_chk2;
    logic tss_chk;
    logic priv_ok;
    logic fault;
    logic noswitch;
    tsg_eff_t eff_d;

    assign is_nest_op = req_q.op inside {TSG_OP_CALL, TSG_OP_SWINT, TSG_OP_HWINT,
        TSG_OP_EXCEPT};
    assign is_gate_op = req_q.via_gate && req_q.op != TSG_OP_INTERRUPT_RETURN_OP;
    assign gate_chk1 = cpl_q <= req_q.gate_dpl; // RULE1
    assign gate_chk2 = req_q.requested_privilege_level <= req_q.gate_dpl; // RULE2
    assign tss_chk = cpl_q <= req_q.tss_dpl && req_q.requested_privilege_level <= req_q.tss_dpl;

    always_comb
    begin
        priv_ok = 1'b1;
        if (req_q.op == TSG_OP_INTERRUPT_RETURN_OP)
        begin
            priv_ok = 1'b1;
        end
        else if (req_q.op inside {TSG_OP_SWINT, TSG_OP_HWINT, TSG_OP_EXCEPT})
        begin
            priv_ok = 1'b1; // RULE17
        end
        else if (req_q.via_gate)
        begin
            priv_ok = gate_chk1 && gate_chk2; // RULE3 RULE4
        end
        else
        begin
            priv_ok = tss_chk;
        end
    end

    always_comb
    begin
        noswitch = req_q.op == TSG_OP_INTERRUPT_RETURN_OP && !nt_q; // RULE8
        fault = 1'b0;
        if (long_mode_q && is_gate_op)
        begin
            fault = 1'b1; // RULE5
        end
        else if (!noswitch && !priv_ok)
        begin
            fault = 1'b1; // RULE16
        end
        else if (req_q.op == TSG_OP_JUMP && req_q.target_busy)
        begin
            fault = 1'b1; // RULE12
        end
        else if (is_nest_op && req_q.target_busy)
        begin
            fault = 1'b1; // RULE14
        end
    end

    always_comb
    begin
        eff_d = '0;
        eff_d.link_sel = cur_sel_q;
        eff_d.new_sel = req_q.target_sel;
        unique case (req_q.op)
            TSG_OP_JUMP:
            begin
                eff_d.old_busy_clr = 1'b1; // RULE11
                eff_d.new_busy_set = 1'b1; // RULE11
            end
            TSG_OP_INTERRUPT_RETURN_OP:
            begin
                eff_d.new_sel = link_q; // RULE8
                eff_d.old_nt_clr = 1'b1; // RULE9
                eff_d.old_busy_clr = 1'b1; // RULE15
            end
            default:
            begin
                eff_d.new_nt_set = 1'b1; // RULE7
                eff_d.new_link_wr = 1'b1; // RULE7
                eff_d.new_busy_set = 1'b1; // RULE13
            end
        endcase
    end

    // Software-written request and mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_q <= '0;
            long_mode_q <= 1'b0;
            cpl_q <= TSG_PL_RESET;
        end
        else if (wr_en && paddr == TSG_ADDR_CTRL)
        begin
            req_q <= tsg_req_t'(pwdata[26:0]);
            long_mode_q <= pwdata[30];
        end
        else if (wr_en && paddr == TSG_ADDR_STATE)
        begin
            cpl_q <= pwdata[17:16];
        end
    end

    // Current task state; a fault leaves it untouched
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nt_q <= 1'b0;
            cur_sel_q <= '0;
            link_q <= '0;
        end
        else if (go && !fault && !noswitch)
        begin
            cur_sel_q <= eff_d.new_sel;
            if (eff_d.new_nt_set)
            begin
                nt_q <= 1'b1; // RULE7
                link_q <= cur_sel_q; // RULE7
            end
            else if (eff_d.old_nt_clr)
            begin
                nt_q <= 1'b0; // RULE9
            end
            // Jump keeps flag and link as they stand RULE6
        end
        else if (wr_en && paddr == TSG_ADDR_STATE)
        begin
            nt_q <= pwdata[18];
            cur_sel_q <= pwdata[15:0];
            link_q <= pwdata[31:19] == '0 ? link_q : link_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            res_q <= TSG_RES_NONE;
            eff_q <= '0;
        end
        else if (go)
        begin
            res_q <= fault ? TSG_RES_FAULT : (noswitch ? TSG_RES_NOSWITCH : TSG_RES_SWITCHED);
            eff_q <= (fault || noswitch) ? '0 : eff_d; // RULE16
        end
    end

    // Interrupt status: set wins over clear
    logic [2:0] ev;
    assign ev = {go && noswitch && !fault, go && fault, go && !fault && !noswitch};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat_q <= '0;
            irq_en_q <= '0;
        end
        else
        begin
            if (wr_en && paddr == TSG_ADDR_IRQ_EN)
            begin
                irq_en_q <= pwdata[2:0];
            end
            irq_stat_q <= (irq_stat_q & ~((wr_en && paddr == TSG_ADDR_IRQ_CLR) ?
                pwdata[2:0] : 3'h0)) | ev;
        end
    end

    assign irq = |(irq_stat_q & irq_en_q);

    always_comb
    begin
        prdata = '0;
        if (rd_en && addr_ok)
        begin
            unique case (paddr)
                TSG_ADDR_CTRL: prdata = {1'b0, long_mode_q, 30'(req_q)};
                TSG_ADDR_STATE: prdata = {13'h0, nt_q, cpl_q, cur_sel_q};
                TSG_ADDR_RESULT: prdata = {7'h0, res_q, eff_q[36:14]};
                TSG_ADDR_IRQ_STAT: prdata = {29'h0, irq_stat_q};
                TSG_ADDR_IRQ_EN: prdata = {29'h0, irq_en_q};
                default: prdata = {16'h0, link_q}; // RULE10 busy kept by memory side
            endcase
        end
    end

endmodule : tsg_ctl

// *** dv/tsg_ctl_properties.sv ***
`timescale 1ns/1ps
module tsg_ctl_properties
    import tsg_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [11:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic irq // Interrupt
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic wr;
    logic cmd;
    logic [31:0] ctrl_q;
    logic fen_q;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign cmd = wr && paddr == TSG_ADDR_CMD && pwdata[0] && fen_q;
    // Shadow of request word and fault enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= 32'h0;
            fen_q <= 1'b0;
        end
        else if (wr && paddr == TSG_ADDR_CTRL)
            ctrl_q <= pwdata;
        else if (wr && paddr == TSG_ADDR_IRQ_EN)
            fen_q <= pwdata[TSG_IRQ_FAULT];
    end
    a_ready_access: assert property (acc |-> pready) else $error("ready low");
    a_err_unmapped: assert property (acc && paddr > TSG_ADDR_CMD |-> pslverr) else $error("no err");
    a_rdata_idle: assert property (!(acc && !pwrite) |-> prdata == 32'h0) else $error("rdata");
    a_irq_masked: assert property (wr && paddr == TSG_ADDR_IRQ_EN && pwdata[2:0] == 3'h0
        |=> !irq) else $error("irq unmasked");
    a_irq_cleared: assert property (wr && paddr == TSG_ADDR_IRQ_CLR && pwdata[2:0] == 3'h7
        |=> !irq) else $error("irq uncleared");
    a_irq_cause: assert property ($rose(irq) |-> $past(wr)) else $error("irq cause");
    a_long_fault: assert property (cmd && ctrl_q[30] && ctrl_q[23] && ctrl_q[26:24] != 3'h5 |=> irq)
        else $error("long gate");
    a_jump_busy: assert property (cmd && ctrl_q[26:24] == 3'h0 && ctrl_q[16] |=> irq)
        else $error("jump busy");
    a_call_busy: assert property (cmd && ctrl_q[26:24] inside {[3'h1:3'h4]} && ctrl_q[16]
        |=> irq) else $error("call busy");
    c_busy: cover property (cmd && ctrl_q[16]);
    c_err: cover property (acc && pslverr);
    c_irq: cover property ($rose(irq));
endmodule : tsg_ctl_properties
bind tsg_ctl tsg_ctl_properties u_tsg_ctl_properties (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// *** dv/tsg_ctl_tb.sv ***
`timescale 1ns/1ps
module tsg_ctl_tb import tsg_pkg::*;;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [31:0] r;
    logic e;
    int err_total = 0;
    int n_checks = 0;
    logic [8:0] tbl [7] = '{9'h100, 9'h1FC, 9'h155, 9'h083, 9'h00F, 9'h08F, 9'h097};
    always #12.5 pclk = ~pclk;
    tsg_ctl u_tsg_ctl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x)
        begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, g, x);
        end
    endtask : chk
    task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            err_total++;
            stop_test();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xf
    function automatic logic [31:0] cw(input logic [2:0] op, input logic g,
        input logic [5:0] pl, input logic b, input logic [15:0] s, input logic lm);
        return {1'b0, lm, 3'h0, op, g, pl, b, s};
    endfunction : cw
    // Bit 31 of st skips the state write
    task automatic sw(input logic [31:0] st, input logic [31:0] c, input logic [6:0] m,
        input logic [6:0] x, input logic [16:0] s);
        if (!st[31])
            xf(1'b1, TSG_ADDR_STATE, st);
        xf(1'b1, TSG_ADDR_CTRL, c);
        xf(1'b1, TSG_ADDR_CMD, 32'h1);
        xf(1'b0, TSG_ADDR_RESULT, 32'h0);
        chk(32'(r[24:18] & m), 32'(x));
        xf(1'b0, TSG_ADDR_STATE, 32'h0);
        chk(32'({r[18], r[15:0]}), 32'(s));
    endtask : sw
    task automatic t_reset;
        xf(1'b0, TSG_ADDR_RESULT, 32'h0);
        chk(r, 32'h0);
        xf(1'b0, TSG_ADDR_IRQ_STAT, 32'h0);
        chk(r, 32'h0);
        xf(1'b0, 12'h01C, 32'h0);
        chk({r[30:0], e}, 32'h1);
        xf(1'b1, TSG_ADDR_IRQ_EN, 32'h2);
    endtask : t_reset
    task automatic t_gate;
        for (int i = 0; i < 7; i++)
            sw({14'h0, tbl[i][7:6], 16'h0100}, cw(3'h0, 1'b1, tbl[i][5:0], 1'b0, 16'h0200,
                1'b0), 7'h7F, tbl[i][8] ? 7'h23 : 7'h40, tbl[i][8] ? 17'h0200 : 17'h0100);
        for (int op = 1; op < 5; op++)
            sw({14'h0, op == 1 ? 2'h0 : 2'h3, 16'h0100}, cw(3'(op), 1'b1, op == 1 ? 6'h0 : 6'h0F,
                1'b0, 16'h0200, 1'b0), 7'h7F, 7'h2D, 17'h10200);
        sw(32'h0100, cw(3'h0, 1'b1, 6'h0, 1'b0, 16'h0200, 1'b1), 7'h7F, 7'h40, 17'h0100);
        sw(32'h0100, cw(3'h1, 1'b1, 6'h0, 1'b0, 16'h0200, 1'b1), 7'h7F, 7'h40, 17'h0100);
    endtask : t_gate
    task automatic t_nest;
        sw(32'h0011, cw(3'h1, 1'b0, 6'h0, 1'b0, 16'h0022, 1'b0), 7'h7F, 7'h2D, 17'h10022);
        sw(32'h80000000, cw(3'h5, 1'b0, 6'h0, 1'b1, 16'h0055, 1'b0), 7'h7F, 7'h32, 17'h0011);
        sw(32'h80000000, cw(3'h5, 1'b0, 6'h0, 1'b1, 16'h0055, 1'b0), 7'h60, 7'h60, 17'h0011);
        sw(32'h40033, cw(3'h0, 1'b0, 6'h0, 1'b0, 16'h0044, 1'b0), 7'h7F, 7'h23, 17'h10044);
    endtask : t_nest
    task automatic t_busy;
        xf(1'b1, TSG_ADDR_IRQ_CLR, 32'h7);
        sw(32'h0033, cw(3'h0, 1'b0, 6'h0, 1'b1, 16'h0044, 1'b0), 7'h7F, 7'h40, 17'h0033);
        xf(1'b0, TSG_ADDR_IRQ_STAT, 32'h0);
        chk({r[2:0], irq}, 32'h5);
        sw(32'h0033, cw(3'h4, 1'b0, 6'h0, 1'b1, 16'h0044, 1'b0), 7'h7F, 7'h40, 17'h0033);
        xf(1'b1, TSG_ADDR_IRQ_EN, 32'h0);
        @(posedge pclk);
        chk(32'(irq), 32'h0);
        xf(1'b1, TSG_ADDR_IRQ_EN, 32'h2);
        @(posedge pclk);
        chk(32'(irq), 32'h1);
        xf(1'b1, TSG_ADDR_IRQ_CLR, 32'h7);
        @(posedge pclk);
        chk(32'(irq), 32'h0);
    endtask : t_busy
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_gate();
        t_nest();
        t_busy();
        stop_test();
    end
endmodule : tsg_ctl_tb
